// ==== hw/tch_host_regs.sv ====
/*
 * tch_host_regs: paged host register block with event capture, hold,
 * coincidence strobe, clock output, packet fifos and interrupt flags.
 * assumes host strobes are one-cycle pulses on core_clk from a bus front
 * end; time, periodic and second-tick inputs come from core_clk logic.
 */
// What this block does
// - strobe output held low while coincidence output enable is clear
// - major/minor mode pulses when hours-seconds and milliseconds all match
// - minor-only mode pulses on milliseconds match, once per second
// - clock output runs at 1, 5 or 10 MHz per rate select
// - event and periodic captures happen only with their enable bits set
// - capture holds time down to 100 ns; demand capture loads the same register
// - with hold enabled, one capture blocks further event or periodic captures
// - host read of release register frees the hold, data undefined
// - any host write to release register captures current time
// - device sets accepted bit; host clears it before requesting processing
// - handshake bit 1 set on second tick rising edge until host clears
// - handshake bit 2 set when a complete output packet is ready
// - handshake bit 4 reads output fifo non-empty status
// - writing handshake bit 4 flushes output fifo, status reads zero
// - host writes bit 7 after loading packet; device acts on input fifo
// - handshake bits 0 to 2 are write-one-to-clear
// - interrupt fires only on status 0 to 1 transition with mask set
// - mask bits 0 to 4 enable sources; bits 5 to 7 ignored
// - sources set status bits regardless of mask
// - status bits 0 to 4 cleared by writing ones
// - status bits: external, periodic, coincidence, second tick, output packet
// - separate 512-byte input and output fifos
// - control bit layout: hold, periodic, edge, external, strobe, mode
// - rate select 00 is 10 MHz, 01 is 5 MHz, 1X is 1 MHz
// - strobe pulse one millisecond wide; rising edge sets status bit 2
// - capture and strobe times are packed BCD, two digits a byte
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module tch_byte_fifo import tch_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] pushData,
  input wire logic pop,
  output logic [7:0] popData,
  output logic full,
  output logic empty
);
  logic [7:0] mem_q [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wrPtr_q;
  logic [FIFO_AW-1:0] rdPtr_q;
  logic [FIFO_AW:0] count_q;
  logic doPush;
  logic doPop;

  assign full = (count_q == FIFO_FULL_COUNT);
  assign empty = (count_q == '0);
  assign doPush = push && !full && !flush;
  assign doPop = pop && !empty && !flush;
  assign popData = mem_q[rdPtr_q];

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem_q[wrPtr_q] <= pushData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) wrPtr_q <= tch_ptr_next(wrPtr_q);
      if (doPop) rdPtr_q <= tch_ptr_next(rdPtr_q);
      count_q <= count_q + {{FIFO_AW{1'b0}}, doPush} - {{FIFO_AW{1'b0}}, doPop};
    end
  end
endmodule : tch_byte_fifo

////////////////////////////////////////////////////////////////////////////////
module tch_host_regs import tch_pkg::*; #(
  parameter int unsigned STROBE_LEN = STROBE_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire tch_host_req_t hostReq,
  output logic [7:0] hostRdData,
  output logic hostIrq,
  input wire tch_time_t currentTime,
  input wire logic eventPin,
  input wire tch_fw_evt_t fwEvt,
  input wire logic fwInPop,
  output logic [7:0] fwInData,
  output logic fwInEmpty,
  input wire logic fwOutPush,
  input wire logic [7:0] fwOutData,
  output logic fwOutFull,
  output logic pktGo,
  output logic coincStrobe,
  output logic clockOut
);
  logic [7:0] page_q;
  logic [7:0] control_q;
  tch_time_t capture_q;
  logic [TB_MS_LO:TB_HOURS][7:0] coinc_q;
  logic holdActive_q;
  logic [2:0] handshake_q;
  logic [INT_COUNT-1:0] intEnable_q;
  logic [INT_COUNT-1:0] intFlags_q;
  logic [INT_COUNT-1:0] intFlags_d;
  logic [INT_COUNT-1:0] intSet;
  logic evtMeta_q, evtSync_q, evtPrev_q;
  logic periodicPrev_q, secondPrev_q;
  logic matchPrev_q;
  logic [STROBE_CNT_W-1:0] strobeCnt_q;
  logic strobe_q;
  logic strobePrev_q;
  logic [31:0] nco_q;
  logic [31:0] ncoInc;
  logic onPage1;
  logic wrEn, rdEn;
  logic eventEdge, periodicRise, secondRise, strobeRise;
  logic autoCapture, releaseRead, releaseWrite;
  logic majorMatch, minorMatch, coincMatch;
  logic outEmpty;
  logic [7:0] outData;
  logic flushOut;

  assign onPage1 = (page_q == PAGE_ONE);
  assign wrEn = hostReq.wr && onPage1;
  assign rdEn = hostReq.rd && onPage1;

  //////////////////////////////////////////////////////////////////////////////
  // page select
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) page_q <= '0;
    else if (hostReq.wr && hostReq.addr == OFS_PAGE) page_q <= hostReq.wrData;
  end

  // control register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) control_q <= CONTROL_RESET;
    else if (wrEn && hostReq.addr == OFS_CONTROL) control_q <= hostReq.wrData;
  end

  //////////////////////////////////////////////////////////////////////////////
  // event input synchroniser and edge select
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evtMeta_q <= 1'b0;
      evtSync_q <= 1'b0;
      evtPrev_q <= 1'b0;
      periodicPrev_q <= 1'b0;
      secondPrev_q <= 1'b0;
    end else begin
      evtMeta_q <= eventPin;
      evtSync_q <= evtMeta_q;
      evtPrev_q <= evtSync_q;
      periodicPrev_q <= fwEvt.periodicPulse;
      secondPrev_q <= fwEvt.secondTick;
    end
  end

  assign eventEdge = control_q[CTL_EDGE_FALL] ? (evtPrev_q && !evtSync_q)
                                              : (!evtPrev_q && evtSync_q);
  assign periodicRise = fwEvt.periodicPulse && !periodicPrev_q;
  assign secondRise = fwEvt.secondTick && !secondPrev_q;

  //////////////////////////////////////////////////////////////////////////////
  // event time capture with hold
  assign autoCapture = !holdActive_q &&
    ((eventEdge && control_q[CTL_EXTERNAL_EN]) ||
     (periodicRise && control_q[CTL_PERIODIC_EN]));
  assign releaseRead = rdEn && hostReq.addr == OFS_RELEASE;
  assign releaseWrite = wrEn && hostReq.addr == OFS_RELEASE;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) capture_q <= '0;
    else if (autoCapture || releaseWrite) capture_q <= currentTime;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) holdActive_q <= 1'b0;
    else if (autoCapture && control_q[CTL_HOLD_EN]) holdActive_q <= 1'b1;
    else if (releaseRead) holdActive_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // coincidence strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) coinc_q <= '0;
    else if (wrEn && hostReq.addr >= OFS_COINC_FIRST && hostReq.addr <= OFS_COINC_LAST)
      coinc_q[hostReq.addr - OFS_EVENT_FIRST] <= hostReq.wrData;
  end

  assign minorMatch = currentTime[TB_MS_HI] == coinc_q[TB_MS_HI] &&
                      currentTime[TB_MS_LO][7:4] == coinc_q[TB_MS_LO][7:4];
  assign majorMatch = currentTime[TB_MS_HI-1:TB_HOURS] == coinc_q[TB_MS_HI-1:TB_HOURS];
  assign coincMatch = control_q[CTL_MINOR_ONLY] ? minorMatch
                                                : (minorMatch && majorMatch);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      matchPrev_q <= 1'b0;
      strobe_q <= 1'b0;
      strobeCnt_q <= '0;
    end else begin
      matchPrev_q <= coincMatch;
      if (!control_q[CTL_COINC_EN]) begin
        strobe_q <= 1'b0;
        strobeCnt_q <= '0;
      end else if (coincMatch && !matchPrev_q && !strobe_q) begin
        strobe_q <= 1'b1;
        strobeCnt_q <= STROBE_CNT_W'(STROBE_LEN - 1);
      end else if (strobeCnt_q != '0) begin
        strobeCnt_q <= strobeCnt_q - 1'b1;
      end else begin
        strobe_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) strobePrev_q <= 1'b0;
    else strobePrev_q <= strobe_q;
  end

  assign strobeRise = strobe_q && !strobePrev_q;
  assign coincStrobe = strobe_q;

  //////////////////////////////////////////////////////////////////////////////
  // clock output rate
  always_comb begin
    if (control_q[CTL_RATE_HI]) ncoInc = NCO_INC_1;
    else if (control_q[CTL_RATE_LO]) ncoInc = NCO_INC_5;
    else ncoInc = NCO_INC_10;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) nco_q <= '0;
    else nco_q <= nco_q + ncoInc;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) clockOut <= 1'b0;
    else clockOut <= nco_q[31];
  end

  //////////////////////////////////////////////////////////////////////////////
  // packet fifos
  assign flushOut = wrEn && hostReq.addr == OFS_HANDSHAKE && hostReq.wrData[HS_NONEMPTY_FLUSH];

  tch_byte_fifo inFifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .flush(fwEvt.inFlush),
    .push(wrEn && hostReq.addr == OFS_FIFO_PORT),
    .pushData(hostReq.wrData),
    .pop(fwInPop),
    .popData(fwInData),
    .full(),
    .empty(fwInEmpty)
  );

  tch_byte_fifo outFifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .flush(flushOut),
    .push(fwOutPush),
    .pushData(fwOutData),
    .pop(rdEn && hostReq.addr == OFS_FIFO_PORT),
    .popData(outData),
    .full(fwOutFull),
    .empty(outEmpty)
  );

  //////////////////////////////////////////////////////////////////////////////
  // handshake register, set wins over clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) handshake_q <= '0;
    else begin
      for (int i = 0; i <= HS_OUT_READY; i++) begin
        if (wrEn && hostReq.addr == OFS_HANDSHAKE && hostReq.wrData[i])
          handshake_q[i] <= 1'b0;
      end
      if (fwEvt.pktAccepted) handshake_q[HS_PKT_ACCEPTED] <= 1'b1;
      if (secondRise) handshake_q[HS_SECOND] <= 1'b1;
      if (fwEvt.outPktReady) handshake_q[HS_OUT_READY] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) pktGo <= 1'b0;
    else pktGo <= wrEn && hostReq.addr == OFS_HANDSHAKE && hostReq.wrData[HS_PKT_GO];
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt flags and enable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) intEnable_q <= '0;
    else if (wrEn && hostReq.addr == OFS_INT_ENABLE)
      intEnable_q <= hostReq.wrData[INT_COUNT-1:0];
  end

  always_comb begin
    intSet = '0;
    intSet[INT_EXTERNAL] = eventEdge;
    intSet[INT_PERIODIC] = periodicRise;
    intSet[INT_COINC] = strobeRise;
    intSet[INT_SECOND] = secondRise;
    intSet[INT_OUT_PACKET] = fwEvt.outPktReady;
    intFlags_d = intFlags_q;
    if (wrEn && hostReq.addr == OFS_INT_FLAGS)
      intFlags_d = intFlags_q & ~hostReq.wrData[INT_COUNT-1:0];
    intFlags_d = intFlags_d | intSet;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) intFlags_q <= '0;
    else intFlags_q <= intFlags_d;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) hostIrq <= 1'b0;
    else hostIrq <= |(intFlags_d & ~intFlags_q & intEnable_q);
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) hostRdData <= '0;
    else if (hostReq.rd) begin
      hostRdData <= '0;
      if (hostReq.addr == OFS_PAGE) hostRdData <= page_q;
      else if (onPage1) begin
        case (hostReq.addr)
          OFS_CONTROL: hostRdData <= control_q;
          OFS_HANDSHAKE: hostRdData <= {3'h0, !outEmpty, 1'b0, handshake_q};
          OFS_INT_ENABLE: hostRdData <= {3'h0, intEnable_q};
          OFS_INT_FLAGS: hostRdData <= {3'h0, intFlags_q};
          OFS_FIFO_PORT: hostRdData <= outData;
          default: begin
            if (hostReq.addr >= OFS_EVENT_FIRST && hostReq.addr <= OFS_EVENT_LAST)
              hostRdData <= capture_q[hostReq.addr - OFS_EVENT_FIRST];
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  strobeOff_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !control_q[CTL_COINC_EN] |=> !coincStrobe) else $error("strobe high while disabled");
  strobeWidth_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (strobeRise && STROBE_LEN > 1 && control_q[CTL_COINC_EN]) |=> coincStrobe || !control_q[CTL_COINC_EN])
    else $error("strobe shorter than set width");
  holdBlocks_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (holdActive_q && !releaseWrite) |=> capture_q == $past(capture_q))
    else $error("capture overwritten while held");
  releaseCapt_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    releaseWrite |=> capture_q == $past(currentTime)) else $error("release write missed capture");
  releaseFree_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (releaseRead && !autoCapture) |=> !holdActive_q) else $error("hold not released");
  secondSet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    secondRise |=> handshake_q[HS_SECOND] && intFlags_q[INT_SECOND])
    else $error("second tick not flagged");
  irqCause_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    hostIrq |-> |($past(intFlags_d) & ~$past(intFlags_q) & $past(intEnable_q)))
    else $error("interrupt without masked rising flag");
  pollMasked_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (eventEdge && intEnable_q == '0) |=> intFlags_q[INT_EXTERNAL] && !hostIrq)
    else $error("flag not set while masked");
  flushEmpty_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    flushOut |=> outEmpty ##1 (hostRdData[HS_NONEMPTY_FLUSH] == 1'b0 || !$past(hostReq.rd)
    || $past(hostReq.addr) != OFS_HANDSHAKE || $past(fwOutPush, 2) || $past(fwOutPush)))
    else $error("flush left data");

endmodule : tch_host_regs

// ==== hw/tch_pkg.sv ====
/*
 * tch_pkg: constants, register map and carrier types for the time
 * capture host interface.
 * assumes a 125 MHz core clock and a host bus front end on that clock.
 */
package tch_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam longint unsigned CLK_HZ = 64'd125_000_000;
  localparam int unsigned STROBE_WIDTH_NS = 1_000_000;
  localparam int unsigned STROBE_CYCLES = STROBE_WIDTH_NS / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CNT_W = 17;
  localparam longint unsigned CLK_OUT_10_HZ = 64'd10_000_000;
  localparam longint unsigned CLK_OUT_5_HZ = 64'd5_000_000;
  localparam longint unsigned CLK_OUT_1_HZ = 64'd1_000_000;
  localparam logic [31:0] NCO_INC_10 = 32'((CLK_OUT_10_HZ << 32) / CLK_HZ);
  localparam logic [31:0] NCO_INC_5 = 32'((CLK_OUT_5_HZ << 32) / CLK_HZ);
  localparam logic [31:0] NCO_INC_1 = 32'((CLK_OUT_1_HZ << 32) / CLK_HZ);

  // fifo geometry
  localparam int unsigned FIFO_DEPTH = 512;
  localparam int unsigned FIFO_AW = 9;
  localparam logic [FIFO_AW:0] FIFO_FULL_COUNT = 10'h200;

  // page select
  localparam logic [3:0] OFS_PAGE = 4'hF;
  localparam logic [7:0] PAGE_ONE = 8'h01;

  // page one offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_EVENT_FIRST = 4'h1;
  localparam logic [3:0] OFS_EVENT_LAST = 4'h9;
  localparam logic [3:0] OFS_COINC_FIRST = 4'h3;
  localparam logic [3:0] OFS_COINC_LAST = 4'h7;
  localparam logic [3:0] OFS_RELEASE = 4'hA;
  localparam logic [3:0] OFS_HANDSHAKE = 4'hB;
  localparam logic [3:0] OFS_INT_ENABLE = 4'hC;
  localparam logic [3:0] OFS_INT_FLAGS = 4'hD;
  localparam logic [3:0] OFS_FIFO_PORT = 4'hE;

  // control bits
  localparam int CTL_HOLD_EN = 0;
  localparam int CTL_PERIODIC_EN = 1;
  localparam int CTL_EDGE_FALL = 2;
  localparam int CTL_EXTERNAL_EN = 3;
  localparam int CTL_COINC_EN = 4;
  localparam int CTL_MINOR_ONLY = 5;
  localparam int CTL_RATE_LO = 6;
  localparam int CTL_RATE_HI = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // handshake bits
  localparam int HS_PKT_ACCEPTED = 0;
  localparam int HS_SECOND = 1;
  localparam int HS_OUT_READY = 2;
  localparam int HS_NONEMPTY_FLUSH = 4;
  localparam int HS_PKT_GO = 7;

  // interrupt sources
  localparam int INT_EXTERNAL = 0;
  localparam int INT_PERIODIC = 1;
  localparam int INT_COINC = 2;
  localparam int INT_SECOND = 3;
  localparam int INT_OUT_PACKET = 4;
  localparam int INT_COUNT = 5;

  // time byte positions
  localparam int TB_HOURS = 2;
  localparam int TB_MS_HI = 5;
  localparam int TB_MS_LO = 6;
  localparam int TIME_BYTES = 9;

  typedef logic [TIME_BYTES-1:0][7:0] tch_time_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } tch_host_req_t;

  typedef struct packed {
    logic periodicPulse;
    logic secondTick;
    logic pktAccepted;
    logic outPktReady;
    logic inFlush;
  } tch_fw_evt_t;

  function automatic logic [FIFO_AW-1:0] tch_ptr_next(input logic [FIFO_AW-1:0] p);
    return p + 9'h001;
  endfunction : tch_ptr_next

endpackage : tch_pkg

// ==== sim/tch_host_model.sv ====
/*
 * tch_host_model: host processor driving paged byte register cycles.
 * assumes one-cycle rd/wr strobes on core_clk, read data the edge after rd.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module tch_host_model import tch_pkg::*; (
  input wire logic core_clk,
  input wire logic [7:0] hostRdData,
  output tch_host_req_t hostReq
);
  initial begin
    hostReq = '0;
  end

  // released bus shows the inverse of the last value
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    hostReq.addr = a;
    hostReq.wrData = d;
    hostReq.wr = 1'b1;
    @(posedge core_clk);
    #1;
    hostReq.wr = 1'b0;
    hostReq.addr = ~a;
    hostReq.wrData = ~d;
  endtask : wrReg

  task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    hostReq.addr = a;
    hostReq.rd = 1'b1;
    @(posedge core_clk);
    #1;
    d = hostRdData;
    hostReq.rd = 1'b0;
    hostReq.addr = ~a;
  endtask : rdReg

  // load packet, clear accepted bit, then request processing
  task automatic sendPacket(input logic [7:0] b0, b1, b2);
    wrReg(OFS_FIFO_PORT, b0);
    wrReg(OFS_FIFO_PORT, b1);
    wrReg(OFS_FIFO_PORT, b2);
    wrReg(OFS_HANDSHAKE, 8'h01);
    wrReg(OFS_HANDSHAKE, 8'h80);
  endtask : sendPacket
endmodule : tch_host_model

// ==== sim/tb_top.sv ====
/*
 * tb_top: directed testbench for the time capture host register block.
 * assumes the host model drives the register bus; fw side driven here.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module tb_top import tch_pkg::*;;
  localparam tch_time_t NSM = {8'hF0, 64'hFFFF_FFFF_FFFF_FFFF};
  localparam tch_time_t TS = 72'h50_10_90_78_56_34_12_23_01;
  localparam tch_time_t TS13 = 72'h50_10_90_78_56_34_13_23_01;
  localparam tch_time_t TN = 72'h50_10_90_00_56_34_12_23_01;
  logic core_clk, arstN, hostIrq, eventPin, fwInPop, fwInEmpty, fwOutPush;
  logic fwOutFull, pktGo, coincStrobe, clockOut, clkOutD;
  logic [7:0] hostRdData, fwInData, fwOutData, d;
  tch_host_req_t hostReq;
  tch_time_t curTime, got;
  tch_fw_evt_t fwEvt;
  int fails, num_checks, irqCnt, strbCnt, clkEdges;

  tch_host_model host (.core_clk(core_clk), .hostRdData(hostRdData), .hostReq(hostReq));
  tch_host_regs #(.STROBE_LEN(8)) dut (.core_clk(core_clk), .arst_n(arstN),
    .hostReq(hostReq), .hostRdData(hostRdData), .hostIrq(hostIrq),
    .currentTime(curTime), .eventPin(eventPin), .fwEvt(fwEvt), .fwInPop(fwInPop),
    .fwInData(fwInData), .fwInEmpty(fwInEmpty), .fwOutPush(fwOutPush),
    .fwOutData(fwOutData), .fwOutFull(fwOutFull), .pktGo(pktGo),
    .coincStrobe(coincStrobe), .clockOut(clockOut));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    clkOutD <= clockOut;
    if (hostIrq === 1'b1) irqCnt++;
    if (coincStrobe === 1'b1) strbCnt++;
    if (clockOut === 1'b1 && clkOutD === 1'b0) clkEdges++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [71:0] s, input logic [71:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
    host.rdReg(a, d);
    chk(n, d, e);
  endtask : rc

  task automatic readCap(input tch_time_t e, input string n);
    for (int k = 0; k < TIME_BYTES; k++) begin
      host.rdReg(OFS_EVENT_FIRST + 4'(k), got[k]);
    end
    chk(n, got & NSM, e & NSM);
  endtask : readCap

  task automatic periodic();
    fwEvt.periodicPulse = 1'b1;
    tick(2);
    fwEvt.periodicPulse = 1'b0;
    tick(2);
  endtask : periodic

  task automatic hit(input logic [7:0] ctl, input tch_time_t t, input int e, input string n);
    int s;
    curTime = TN;
    host.wrReg(OFS_CONTROL, ctl);
    tick(2);
    s = strbCnt;
    curTime = t;
    tick(20);
    chk(n, strbCnt - s, e);
  endtask : hit

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tRegs();
    rc(OFS_CONTROL, 8'h00, "page0");
    host.wrReg(OFS_PAGE, PAGE_ONE);
    rc(OFS_HANDSHAKE, 8'h00, "hs rst");
    rc(OFS_INT_FLAGS, 8'h00, "flag rst");
    host.wrReg(OFS_CONTROL, 8'hA5);
    rc(OFS_CONTROL, 8'hA5, "control");
    host.wrReg(OFS_INT_ENABLE, 8'hFF);
    rc(OFS_INT_ENABLE, 8'h1F, "mask");
    host.wrReg(OFS_INT_ENABLE, 8'h00);
    host.wrReg(OFS_CONTROL, 8'h00);
    $display("test regs done");
  endtask : tRegs

  task automatic tCapture();
    curTime = 72'h10_23_45_67_59_59_23_65_03;
    host.wrReg(OFS_CONTROL, 8'h03);
    periodic();
    readCap(72'h10_23_45_67_59_59_23_65_03, "cap1");
    rc(OFS_INT_FLAGS, 8'h02, "flag per");
    host.wrReg(OFS_INT_FLAGS, 8'hFF);
    rc(OFS_INT_FLAGS, 8'h00, "flag clr");
    curTime = TS;
    periodic();
    readCap(72'h10_23_45_67_59_59_23_65_03, "held");
    rc(OFS_RELEASE, 8'h00, "release");
    periodic();
    readCap(TS, "cap2");
    host.wrReg(OFS_CONTROL, 8'h00);
    curTime = TS13;
    periodic();
    readCap(TS, "no en");
    host.wrReg(OFS_RELEASE, 8'h5A);
    readCap(TS13, "demand");
    $display("test capture done");
  endtask : tCapture

  task automatic tEvent();
    rc(OFS_RELEASE, 8'h00, "unhold");
    host.wrReg(OFS_CONTROL, 8'h08);
    host.wrReg(OFS_INT_FLAGS, 8'h1F);
    curTime = TN;
    eventPin = 1'b1;
    tick(6);
    readCap(TN, "ev rise");
    rc(OFS_INT_FLAGS, 8'h01, "flag ev");
    host.wrReg(OFS_CONTROL, 8'h0C);
    curTime = TS;
    eventPin = 1'b0;
    tick(6);
    readCap(TS, "ev fall");
    host.wrReg(OFS_CONTROL, 8'h00);
    $display("test event done");
  endtask : tEvent

  task automatic tIrq();
    int s;
    host.wrReg(OFS_INT_FLAGS, 8'h1F);
    s = irqCnt;
    periodic();
    chk("irq masked", irqCnt - s, 0);
    rc(OFS_INT_FLAGS, 8'h02, "poll");
    host.wrReg(OFS_INT_ENABLE, 8'h02);
    periodic();
    chk("irq no edge", irqCnt - s, 0);
    host.wrReg(OFS_INT_FLAGS, 8'h02);
    periodic();
    chk("irq", irqCnt - s, 1);
    host.wrReg(OFS_INT_ENABLE, 8'h00);
    host.wrReg(OFS_INT_FLAGS, 8'h1F);
    $display("test irq done");
  endtask : tIrq

  task automatic tHandshake();
    fwEvt.pktAccepted = 1'b1;
    fwEvt.secondTick = 1'b1;
    fwEvt.outPktReady = 1'b1;
    tick(1);
    fwEvt.pktAccepted = 1'b0;
    fwEvt.outPktReady = 1'b0;
    rc(OFS_HANDSHAKE, 8'h07, "hs set");
    rc(OFS_INT_FLAGS, 8'h18, "flag sec out");
    host.wrReg(OFS_HANDSHAKE, 8'h01);
    rc(OFS_HANDSHAKE, 8'h06, "w1c one");
    host.wrReg(OFS_HANDSHAKE, 8'h68);
    rc(OFS_HANDSHAKE, 8'h06, "reserved");
    host.wrReg(OFS_HANDSHAKE, 8'h06);
    rc(OFS_HANDSHAKE, 8'h00, "w1c two");
    fwEvt.secondTick = 1'b0;
    host.sendPacket(8'h01, 8'h41, 8'h17);
    chk("go", pktGo, 1'b1);
    chk("in head", fwInData, 8'h01);
    for (int k = 0; k < 2; k++) begin
      fwInPop = 1'b1;
      tick(1);
    end
    fwInPop = 1'b0;
    chk("in third", fwInData, 8'h17);
    fwEvt.inFlush = 1'b1;
    tick(1);
    fwEvt.inFlush = 1'b0;
    chk("in empty", fwInEmpty, 1'b1);
    host.wrReg(OFS_INT_FLAGS, 8'h1F);
    $display("test handshake done");
  endtask : tHandshake

  task automatic tFifo();
    fwOutPush = 1'b1;
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      fwOutData = 8'(k);
      tick(1);
    end
    fwOutPush = 1'b0;
    chk("out full", fwOutFull, 1'b1);
    rc(OFS_HANDSHAKE, 8'h10, "nonempty");
    rc(OFS_FIFO_PORT, 8'h00, "pop0");
    rc(OFS_FIFO_PORT, 8'h01, "pop1");
    host.wrReg(OFS_HANDSHAKE, 8'h10);
    rc(OFS_HANDSHAKE, 8'h00, "flush");
    $display("test fifo done");
  endtask : tFifo

  task automatic tStrobe();
    int s;
    for (int k = 2; k <= 6; k++) begin
      host.wrReg(OFS_COINC_FIRST + 4'(k - 2), TS[k]);
    end
    host.wrReg(OFS_INT_ENABLE, 8'h04);
    s = irqCnt;
    hit(8'h00, TS, 0, "strobe off");
    hit(8'h10, TS, 8, "major");
    hit(8'h10, TS13, 0, "major miss");
    hit(8'h30, TS13, 8, "minor");
    rc(OFS_INT_FLAGS, 8'h04, "flag strobe");
    chk("irq strobe", irqCnt - s, 1);
    host.wrReg(OFS_INT_ENABLE, 8'h00);
    $display("test strobe done");
  endtask : tStrobe

  task automatic tClock();
    int exp [4] = '{80, 40, 8, 8};
    int s;
    for (int k = 0; k < 4; k++) begin
      host.wrReg(OFS_CONTROL, 8'(k << 6));
      tick(10);
      s = clkEdges;
      tick(1000);
      chk("clock rate", (clkEdges - s >= exp[k] - 1) && (clkEdges - s <= exp[k] + 1), 1'b1);
    end
    $display("test clock done");
  endtask : tClock

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arstN = 1'b0;
    curTime = '0;
    eventPin = 1'b0;
    fwEvt = '0;
    fwInPop = 1'b0;
    fwOutPush = 1'b0;
    fwOutData = 8'h00;
    tick(4);
    arstN = 1'b1;
    tRegs();
    tCapture();
    tEvent();
    tIrq();
    tHandshake();
    tFifo();
    tStrobe();
    tClock();
    print_verdict();
  end

  initial begin
    #600000;
    fails++;
    print_verdict();
  end
endmodule : tb_top
